// ===== logic/bms_params.svh
// Boot mode sequencer constants: strap codes, search limits, task numbers.
// Assumes inclusion by bare name from the package and design modules.
`ifndef BMS_PARAMS_SVH
`define BMS_PARAMS_SVH
// Strap codes
`define BMS_CODE_TEST_PORT   4'h0
`define BMS_CODE_FLASH24     4'h1
`define BMS_CODE_FLASH32     4'h2
`define BMS_CODE_CARD0       4'h3
`define BMS_CODE_PARALLEL    4'h4
`define BMS_CODE_CARD1       4'h5
`define BMS_CODE_EMBEDDED    4'h6
`define BMS_CODE_USB         4'h7
`define BMS_CODE_CARD1_SHIFT 4'hE
// Width request codes
`define BMS_REQ_X1           2'h0
`define BMS_REQ_X2           2'h1
// Image slots are 32 KB apart
`define BMS_SLOT_SHIFT       15
`define BMS_SLOT_BYTES       32'h0000_8000
// Search limits in slots or files
`define BMS_LIM_F24_SINGLE   14'h0200
`define BMS_LIM_F24_DUAL     14'h0400
`define BMS_LIM_F32_SINGLE   14'h2000
`define BMS_LIM_X8_WINDOW    14'h0400
`define BMS_LIM_PARALLEL     14'h1000
`define BMS_LIM_CARD_FILES   14'h2000
`define BMS_LIM_ONE          14'h0001
// Strap settle wait after reset release
`define BMS_SYNC_WAIT        2'h3
// Pre-boot task numbers
`define BMS_TASK_LAST_EXT    4'h9
`define BMS_TASK_RELEASE     4'hA
`define BMS_TASK_SERVICE     4'hB
`endif

// ===== logic/bms_pkg.sv
// Boot mode sequencer types: states, sources, widths and the task sequencer state record.
// Assumes bms_params.svh is on the include path.
`include "bms_params.svh"
package bms_pkg;
  // Boot sources after decode
  typedef enum logic [3:0] {
    SRC_NONE, SRC_FLASH24, SRC_FLASH32, SRC_CARD0, SRC_CARD1, SRC_CARD1_SHIFTED,
    SRC_EMBEDDED_CARD, SRC_PARALLEL_FLASH, SRC_USB, SRC_TEST_PORT
  } bms_src_t;
  // Read widths
  typedef enum logic [1:0] {WID_X1 = 2'b00, WID_X2 = 2'b01, WID_X4 = 2'b10, WID_X8 = 2'b11}
    bms_width_t;
  // Boot flow states
  typedef enum logic [3:0] {
    ST_LATCH = 4'b0000, ST_PREBOOT = 4'b0001, ST_OCM = 4'b0010, ST_MODE = 4'b0011,
    ST_WAIT = 4'b0100, ST_LOAD = 4'b0101, ST_DONE = 4'b0110, ST_ERROR = 4'b0111
  } bms_state_t;
  // Pre-boot task sequencer states
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b000, SQ_WAIT = 3'b001, SQ_SERVICE = 3'b010, SQ_FAULT = 3'b011
  } bms_seq_state_t;
  // Task sequencer state record
  typedef struct packed {
    bms_seq_state_t st;
    logic [3:0]     id;
    logic           start;
    logic           rel;
    logic           fault;
    logic           svc;
    logic           failed;
  } bms_seq_t;
endpackage

// ===== logic/bms_task_seq.sv
// Pre-boot task sequencer: issues tasks 0..9, then either releases and enters service in the same step, or faults.
// Assumes task_done and task_fail are one-cycle pulses from logic on clk.
`include "bms_params.svh"
module bms_task_seq
  import bms_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control from boot flow
  input  wire logic       go,
  input  wire logic       mode_ok,
  // Task executor handshake
  input  wire logic       task_done,
  input  wire logic       task_fail,
  output logic            task_start,
  output logic [3:0]      task_id,
  // Results
  output logic            release_csu,
  output logic            fault,
  output logic            service
);
  bms_seq_t s_reg;  // Registered state
  bms_seq_t s_next; // Next state

  // Task stepping
  always_comb
  begin
    s_next = s_reg;
    s_next.start = 1'b0;
    case (s_reg.st)
      SQ_IDLE:
      begin
        // First task issued on go
        if (go)
        begin
          s_next.st    = SQ_WAIT;
          s_next.id    = 4'h0;
          s_next.start = 1'b1;
        end
      end
      SQ_WAIT:
      begin
        if (task_done)
        begin
          // Any failure, supply check included, blocks the release
          s_next.failed = s_reg.failed | task_fail;
          if (s_reg.id != `BMS_TASK_LAST_EXT)
          begin
            s_next.id    = s_reg.id + 4'h1; // R18 R19
            s_next.start = 1'b1;
          end
          else if (mode_ok && !(s_reg.failed | task_fail))
          begin
            s_next.id  = `BMS_TASK_SERVICE; // R19
            s_next.rel = 1'b1;
            s_next.svc = 1'b1;
            s_next.st  = SQ_SERVICE;
          end
          else
          begin
            // Bad strap or task failure: error state, no release
            s_next.id    = `BMS_TASK_RELEASE; // R19 R24
            s_next.fault = 1'b1;
            s_next.st    = SQ_FAULT;
          end
        end
      end
      default:
      begin
        s_next.st = s_reg.st; // Terminal until reset
      end
    endcase
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
      s_reg <= '{st: SQ_IDLE, id: 4'h0, default: 1'b0};
    else
      s_reg <= s_next;
  end

  assign task_start  = s_reg.start;
  assign task_id     = s_reg.id;
  assign release_csu = s_reg.rel;
  assign fault       = s_reg.fault;
  assign service     = s_reg.svc;

  a_task_next: assert property (@(posedge clk) disable iff (rst) // R18
    (s_reg.st == SQ_WAIT && task_done && s_reg.id != `BMS_TASK_LAST_EXT)
      |=> task_start && task_id == $past(task_id) + 4'h1)
    else $error("pre-boot task skipped or repeated");
  a_release_gate: assert property (@(posedge clk) disable iff (rst) // R19
    $rose(release_csu) |-> $past(task_id) == `BMS_TASK_LAST_EXT && !fault && service)
    else $error("release without finishing tasks");
endmodule

// ===== logic/bms_top.sv
// Boot mode sequencer: strap latch, pre-boot tasks, boot source decode, image search.
// Assumes straps and hw_irq_pin are asynchronous pins; all else is on clk.
// Operation
// R01: Latch strap pins into boot mode register
// R02: Codes 1,2 select 24/32-bit serial flash
// R03: Codes 5,3,E select card one, zero, shifted
// R04: Code 4 parallel flash, 8-bit path only
// R05: Serial flash x1/x2/x4, x8 with two devices
// R06: Single transfer rate; stacked pair unsupported
// R07: x8 search covers first 256 Mb only
// R08: Small flash keeps images below 128 Mb
// R09: Card boot FAT16/32, search 8,192 files
// R10: Test-port boot offers no secure boot
// R11: USB device only, secure ok, needs DRAM
// R12: USB: no search, fallback or execute-in-place
// R13: USB host image fits 256 KB RAM
// R14: Execute-in-place only single serial flash
// R15: Secondary from listed device classes only
// R16: Secondary differs in class from primary; the code does not check this and takes any listed class
// R17: No secondary configured: primary reused
// R18: Pre-boot tasks 0 to 5 in order
// R19: Tasks 6 to 11, release or error
// R20: Service mode answers software and hardware requests
// R21: Unit inits RAM, reads mode, loads image
// R22: Probe 32 KB slots, need id and checksum
// R23: Failed image: offset plus one, retry to limit
// R24: Unknown strap code goes to error state
`include "bms_params.svh"
module bms_top
  import bms_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Straps and board options
  input  wire logic [3:0]  mode_pins,
  input  wire logic        sec_mode_valid,
  input  wire logic [3:0]  sec_mode_code,
  input  wire logic        flash_dual,
  input  wire logic        flash_stacked,
  input  wire logic [1:0]  flash_width_req,
  input  wire logic        dram_present,
  input  wire logic        usb_boot_disable_option,
  input  wire logic        load_pmu_fw,
  // Pre-boot task executor
  input  wire logic        task_done,
  input  wire logic        task_fail,
  output bms_pkg::bms_src_t   primary_src,
  output bms_pkg::bms_src_t   secondary_src,
  output bms_pkg::bms_width_t read_width,
  output logic             task_start,
  output logic [3:0]       task_id,
  // Configuration unit side
  input  wire logic        ocm_init_done,
  input  wire logic        probe_done,
  input  wire logic        probe_id_ok,
  input  wire logic        probe_csum_ok,
  input  wire logic        load_done,
  output logic             csu_release,
  output logic             ocm_init_req,
  output logic             probe_req,
  output logic [31:0]      probe_addr,
  output logic             load_req,
  output logic             load_pmu_fw_req,
  // Boot mode register and limits
  output logic [3:0]       boot_mode_reg,
  output logic [13:0]      search_limit,
  output logic             secure_allowed,
  output logic             xip_allowed,
  output logic             multi_image_allowed,
  output logic             fat_fs_required,
  output logic             single_transfer_rate,
  output logic             boot_done,
  output logic             boot_error,
  // Service mode requests
  input  wire logic        sw_irq,
  input  wire logic        hw_irq_pin,
  output logic             service_mode,
  output logic             service_ack,
  output logic [1:0]       service_cause
);
  // All flow state in one record
  typedef struct packed {
    bms_state_t st;
    logic [3:0] m1;       // Strap sync stage one
    logic [3:0] m2;       // Strap sync stage two
    logic       h1;       // Hardware request sync one
    logic       h2;       // Hardware request sync two
    logic [1:0] cnt;      // Settle counter
    logic [3:0] mode;     // Boot mode register
    logic       latched;
    logic       code_ok;
    logic       seq_go;
    bms_src_t   prim;
    bms_src_t   sec;
    bms_width_t wid;
    logic [13:0] lim;
    logic [13:0] idx;     // Multi-image offset
    logic [31:0] addr;
    logic       secure;
    logic       execute_in_place;
    logic       multi;
    logic       fat;
    logic       str;
    logic       on_chip_ram;
    logic       probe;
    logic       load;
    logic       platform_management_unit;
    logic       done;
    logic       err;
    logic       ack;
    logic [1:0] cause;
  } bms_top_t;

  bms_top_t s_reg;  // Registered state
  bms_top_t s_next; // Next state
  logic seq_release; // From task sequencer
  logic seq_fault;
  logic seq_service;

  // Strap code to source class
  function automatic bms_src_t code_to_src(input logic [3:0] code);
    bms_src_t r;
    r = SRC_NONE;
    if (code == `BMS_CODE_FLASH24)           r = SRC_FLASH24;        // R02
    else if (code == `BMS_CODE_FLASH32)      r = SRC_FLASH32;        // R02
    else if (code == `BMS_CODE_CARD0)        r = SRC_CARD0;          // R03
    else if (code == `BMS_CODE_CARD1)        r = SRC_CARD1;          // R03
    else if (code == `BMS_CODE_CARD1_SHIFT)  r = SRC_CARD1_SHIFTED;  // R03
    else if (code == `BMS_CODE_EMBEDDED)     r = SRC_EMBEDDED_CARD;
    else if (code == `BMS_CODE_PARALLEL)     r = SRC_PARALLEL_FLASH; // R04
    else if (code == `BMS_CODE_USB)          r = SRC_USB;
    else if (code == `BMS_CODE_TEST_PORT)    r = SRC_TEST_PORT;
    return r;
  endfunction

  // Both serial flash variants are one class
  function automatic logic is_flash(input bms_src_t src);
    return (src == SRC_FLASH24) || (src == SRC_FLASH32);
  endfunction

  // Pre-boot task order lives in its own sequencer
  bms_task_seq u_seq (
    .clk         (clk),
    .rst         (rst),
    .go          (s_reg.seq_go),
    .mode_ok     (s_reg.code_ok),
    .task_done   (task_done),
    .task_fail   (task_fail),
    .task_start  (task_start),
    .task_id     (task_id),
    .release_csu (seq_release),
    .fault       (seq_fault),
    .service     (seq_service)
  );

  // Boot flow
  always_comb
  begin
    bms_src_t   p;
    bms_src_t   q;
    logic       dual;
    p = code_to_src(s_reg.mode);
    q = code_to_src(sec_mode_code);
    dual = flash_dual && is_flash(p);
    s_next = s_reg;
    s_next.m1 = mode_pins;
    s_next.m2 = s_reg.m1;
    s_next.h1 = hw_irq_pin;
    s_next.h2 = s_reg.h1;
    s_next.seq_go = 1'b0;
    s_next.ack = 1'b0;
    // Service requests only once the task list is through
    if (seq_service && (sw_irq || s_reg.h2))
    begin
      s_next.ack   = 1'b1; // R20
      s_next.cause = {s_reg.h2, sw_irq};
    end
    case (s_reg.st)
      ST_LATCH:
      begin
        // Wait out the synchroniser before catching straps once
        s_next.cnt = s_reg.cnt + 2'h1;
        if (s_reg.cnt == `BMS_SYNC_WAIT)
        begin
          s_next.mode    = s_reg.m2; // R01
          s_next.latched = 1'b1;
          s_next.code_ok = (code_to_src(s_reg.m2) != SRC_NONE); // R24
          s_next.seq_go  = 1'b1;
          s_next.st      = ST_PREBOOT;
        end
      end
      ST_PREBOOT:
      begin
        if (seq_fault)
        begin
          s_next.err = 1'b1; // R24
          s_next.st  = ST_ERROR;
        end
        else if (seq_release)
        begin
          s_next.on_chip_ram = 1'b1; // R21
          s_next.st  = ST_OCM;
        end
      end
      ST_OCM:
      begin
        if (ocm_init_done)
        begin
          s_next.on_chip_ram = 1'b0;
          s_next.st  = ST_MODE; // R21
        end
      end
      ST_MODE:
      begin
        // Decode from the latched register, never the live pins
        s_next.prim   = p; // R01 R21
        s_next.secure = (p != SRC_TEST_PORT); // R10 R11
        s_next.multi  = (p != SRC_USB) && (p != SRC_TEST_PORT); // R12
        s_next.execute_in_place    = is_flash(p) && !dual; // R14
        s_next.fat    = (p == SRC_CARD0) || (p == SRC_CARD1) ||
                        (p == SRC_CARD1_SHIFTED) || (p == SRC_EMBEDDED_CARD); // R09
        s_next.str    = is_flash(p); // R06
        s_next.wid    = WID_X8;
        if (p == SRC_PARALLEL_FLASH)
          s_next.wid = WID_X8; // R04
        else if (dual)
          s_next.wid = WID_X8; // R05
        else if (is_flash(p) && flash_width_req == `BMS_REQ_X1)
          s_next.wid = WID_X1; // R05
        else if (is_flash(p) && flash_width_req == `BMS_REQ_X2)
          s_next.wid = WID_X2; // R05
        else if (is_flash(p))
          s_next.wid = WID_X4; // R05
        // Search ranges per source
        if (p == SRC_FLASH24)
          s_next.lim = dual ? `BMS_LIM_F24_DUAL : `BMS_LIM_F24_SINGLE;
        else if (p == SRC_FLASH32)
          s_next.lim = dual ? `BMS_LIM_X8_WINDOW : `BMS_LIM_F32_SINGLE; // R07
        else if (p == SRC_PARALLEL_FLASH)
          s_next.lim = `BMS_LIM_PARALLEL;
        else if (s_next.fat)
          s_next.lim = `BMS_LIM_CARD_FILES; // R09
        else
          s_next.lim = `BMS_LIM_ONE; // R12
        // Secondary: listed class, else the primary again
        if (sec_mode_valid && q != SRC_NONE && q != SRC_TEST_PORT)
          s_next.sec = q; // R15
        else
          s_next.sec = p; // R17
        s_next.idx  = 14'h0000;
        s_next.addr = 32'h0000_0000;
        if (p == SRC_NONE || (is_flash(p) && flash_stacked) ||
            (p == SRC_USB && (!dram_present || usb_boot_disable_option)))
        begin
          s_next.err = 1'b1; // R06 R11 R24
          s_next.st  = ST_ERROR;
        end
        else if (p == SRC_TEST_PORT)
        begin
          // Image arrives over the test port; nothing to fetch
          s_next.done = 1'b1;
          s_next.st   = ST_DONE;
        end
        else
        begin
          s_next.probe = 1'b1; // R22
          s_next.st    = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (probe_done)
        begin
          if (probe_id_ok && probe_csum_ok)
          begin
            s_next.probe = 1'b0; // R22
            s_next.load  = 1'b1; // R21
            s_next.platform_management_unit   = load_pmu_fw;
            s_next.st    = ST_LOAD;
          end
          else if (s_reg.multi && (s_reg.idx + 14'h0001) < s_reg.lim)
          begin
            // Next slot, request stays up for the new address
            s_next.idx  = s_reg.idx + 14'h0001; // R23
            s_next.addr = s_reg.addr + `BMS_SLOT_BYTES; // R22 R23
          end
          else
          begin
            s_next.probe = 1'b0;
            s_next.err   = 1'b1; // R23
            s_next.st    = ST_ERROR;
          end
        end
      end
      ST_LOAD:
      begin
        if (load_done)
        begin
          s_next.load = 1'b0;
          s_next.platform_management_unit  = 1'b0;
          s_next.done = 1'b1;
          s_next.st   = ST_DONE;
        end
      end
      default:
      begin
        s_next.st = s_reg.st; // Done and error hold until reset
      end
    endcase
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
      s_reg <= '{st: ST_LATCH, prim: SRC_NONE, sec: SRC_NONE, wid: WID_X1, default: '0};
    else
      s_reg <= s_next;
  end

  // Outputs from the record, except csu_release and service_mode from the task sequencer
  assign primary_src          = s_reg.prim;
  assign secondary_src        = s_reg.sec;
  assign read_width           = s_reg.wid;
  assign csu_release          = seq_release;
  assign ocm_init_req         = s_reg.on_chip_ram;
  assign probe_req            = s_reg.probe;
  assign probe_addr           = s_reg.addr;
  assign load_req             = s_reg.load;
  assign load_pmu_fw_req      = s_reg.platform_management_unit;
  assign boot_mode_reg        = s_reg.mode;
  assign search_limit         = s_reg.lim;
  assign secure_allowed       = s_reg.secure;
  assign xip_allowed          = s_reg.execute_in_place;
  assign multi_image_allowed  = s_reg.multi;
  assign fat_fs_required      = s_reg.fat;
  assign single_transfer_rate = s_reg.str;
  assign boot_done            = s_reg.done;
  assign boot_error           = s_reg.err;
  assign service_mode         = seq_service;
  assign service_ack          = s_reg.ack;
  assign service_cause        = s_reg.cause;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_mode_hold: assert property (s_reg.latched |=> $stable(boot_mode_reg)) // R01
    else $error("boot mode register changed after latch");
  a_flash_decode: assert property ((s_reg.st == ST_WAIT && boot_mode_reg ==
    `BMS_CODE_FLASH32) |-> primary_src == SRC_FLASH32) // R02
    else $error("flash strap decoded wrongly");
  a_parallel_width: assert property ((s_reg.st == ST_WAIT &&
    primary_src == SRC_PARALLEL_FLASH) |-> read_width == WID_X8) // R04
    else $error("parallel flash not on 8-bit path");
  a_stack_error: assert property ((s_reg.st == ST_MODE && flash_stacked &&
    is_flash(code_to_src(s_reg.mode))) |=> boot_error && !probe_req) // R06
    else $error("stacked flash not refused");
  a_test_nosecure: assert property ((s_reg.st == ST_DONE &&
    primary_src == SRC_TEST_PORT) |-> !secure_allowed) // R10
    else $error("secure boot offered on test port");
  a_usb_dram: assert property ((s_reg.st == ST_MODE && !dram_present &&
    s_reg.mode == `BMS_CODE_USB) |=> boot_error ##1 boot_error) // R11
    else $error("USB boot without DRAM not refused");
  a_usb_single: assert property ((s_reg.st == ST_WAIT && primary_src == SRC_USB &&
    probe_done && !probe_id_ok) |=> boot_error && !probe_req) // R12
    else $error("USB boot retried an image");
  a_xip_only: assert property (xip_allowed |-> is_flash(primary_src) &&
    read_width != WID_X8) // R14
    else $error("execute-in-place outside single serial flash");
  a_sec_default: assert property ((s_reg.st == ST_MODE && !sec_mode_valid)
    |=> secondary_src == primary_src) // R17
    else $error("secondary not defaulted to primary");
  a_retry_step: assert property ((s_reg.st == ST_WAIT && probe_done && !probe_csum_ok &&
    probe_req && s_next.st == ST_WAIT)
      |=> probe_addr == $past(probe_addr) + `BMS_SLOT_BYTES && probe_req) // R22 R23
    else $error("search offset not advanced by one slot");
  a_bad_code: assert property ((s_reg.st == ST_PREBOOT && !s_reg.code_ok)
    |-> !csu_release) // R24
    else $error("unknown strap code released the unit");
endmodule

// ===== testbench/bms_partner.sv
// Boot device model: answers ocm, probe and load requests with pulses.
// Assumes requests are levels on clk; answers change 1 ns after an edge.
module bms_partner (
  // Clock
  input  wire logic        clk,
  // Requests
  input  wire logic        ocm_init_req,
  input  wire logic        probe_req,
  input  wire logic [31:0] probe_addr,
  input  wire logic        load_req,
  // Answers
  output logic             ocm_init_done,
  output logic             probe_done,
  output logic             probe_id_ok,
  output logic             probe_csum_ok,
  output logic             load_done,
  // Scenario knobs
  input  wire logic [3:0]  lat,
  input  wire logic [13:0] good_slot,
  input  wire logic [13:0] sum_bad_slot
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]  wait_cnt; // Cycles spent on the current request
  logic [13:0] slot;     // 32 KB slot under probe
  assign slot = probe_addr[28:15];
  initial
  begin
    {ocm_init_done, probe_done, probe_id_ok, probe_csum_ok, load_done} = 5'h00;
    wait_cnt = 4'h0;
  end
  // Answer after lat cycles; a slow device simply counts longer
  always @(posedge clk)
  begin
    #1;
    ocm_init_done = 1'b0;
    probe_done = 1'b0;
    load_done = 1'b0;
    // Qualifiers mean nothing outside an answer, so keep them moving
    probe_id_ok = ~probe_id_ok;
    probe_csum_ok = ~probe_csum_ok;
    if (!(ocm_init_req || probe_req || load_req))
      wait_cnt = 4'h0;
    else if (wait_cnt < lat)
      wait_cnt = wait_cnt + 4'h1;
    else
    begin
      wait_cnt = 4'h0;
      ocm_init_done = ocm_init_req;
      // Image is one small slot: fits 256 KB RAM, sits below 128 Mb
      load_done = load_req;
      probe_done = probe_req;
      probe_id_ok = (slot == good_slot) || (slot == sum_bad_slot);
      probe_csum_ok = (slot == good_slot);
    end
  end
endmodule

// ===== testbench/tb.sv
// Bench for the boot mode sequencer: decode, pre-boot order, search, service.
// Assumes bms_partner stands in for the boot device.
module tb
  import bms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Bench-driven inputs
  logic        clk, rst, sec_mode_valid, flash_dual, flash_stacked, dram_present;
  logic        usb_boot_disable_option, load_pmu_fw, task_done, task_fail, sw_irq, hw_irq_pin;
  logic [3:0]  mode_pins, sec_mode_code, lat;
  logic [1:0]  flash_width_req;
  logic [13:0] good_slot, sum_bad_slot;
  // Partner answers
  logic        ocm_init_done, probe_done, probe_id_ok, probe_csum_ok, load_done;
  // Design outputs
  bms_src_t    primary_src, secondary_src;
  bms_width_t  read_width;
  logic        task_start, csu_release, ocm_init_req, probe_req, load_req, load_pmu_fw_req;
  logic        secure_allowed, xip_allowed, multi_image_allowed, fat_fs_required;
  logic        single_transfer_rate, boot_done, boot_error, service_mode, service_ack;
  logic [3:0]  task_id, boot_mode_reg;
  logic [31:0] probe_addr;
  logic [13:0] search_limit;
  logic [1:0]  service_cause;
  int          err_total, checks, probes, pmu_seen;
  bms_top DUT (.clk, .rst, .mode_pins, .sec_mode_valid, .sec_mode_code, .flash_dual,
    .flash_stacked, .flash_width_req, .dram_present, .usb_boot_disable_option, .load_pmu_fw,
    .task_done, .task_fail, .primary_src, .secondary_src, .read_width, .task_start, .task_id,
    .ocm_init_done, .probe_done, .probe_id_ok, .probe_csum_ok, .load_done, .csu_release,
    .ocm_init_req, .probe_req, .probe_addr, .load_req, .load_pmu_fw_req, .boot_mode_reg,
    .search_limit, .secure_allowed, .xip_allowed, .multi_image_allowed, .fat_fs_required,
    .single_transfer_rate, .boot_done, .boot_error, .sw_irq, .hw_irq_pin, .service_mode,
    .service_ack, .service_cause);
  bms_partner far_end (.clk, .ocm_init_req, .probe_req, .probe_addr, .load_req,
    .ocm_init_done, .probe_done, .probe_id_ok, .probe_csum_ok, .load_done, .lat,
    .good_slot, .sum_bad_slot);
  // 125 MHz clock
  always #4 clk = ~clk;
  // Probe answers taken, and the firmware flag at the load answer
  always @(posedge clk)
  begin
    if (probe_done && probe_req)
      probes++;
    if (load_done && load_req)
      pmu_seen = load_pmu_fw_req;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic test_done;
    if (err_total == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  // Reset with straps, walk tasks 0..9, wait for the boot to settle
  task automatic boot(input logic [3:0] code, input int fail_at);
    int n;
    tick();
    rst = 1'b1;
    mode_pins = code;
    probes = 0;
    repeat (10) tick();
    rst = 1'b0;
    for (int i = 0; i < 10; i++)
    begin
      n = 0;
      while (task_start !== 1'b1 && n < 20)
      begin
        tick();
        n++;
      end
      chk(task_id, i, "task order");
      task_done = 1'b1;
      task_fail = (i == fail_at);
      tick();
    end
    task_done = 1'b0;
    task_fail = 1'b0;
    n = 0;
    while (boot_done !== 1'b1 && boot_error !== 1'b1 && n < 300)
    begin
      tick();
      n++;
    end
    chk(boot_mode_reg, code, "mode reg");
  endtask
  // Every strap code except the test port (0) with its limits
  task automatic t_modes;
    logic [3:0]  code [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hE};
    bms_src_t    src [8] = '{SRC_FLASH24, SRC_FLASH32, SRC_CARD0, SRC_PARALLEL_FLASH,
                             SRC_CARD1, SRC_EMBEDDED_CARD, SRC_USB, SRC_CARD1_SHIFTED};
    logic [13:0] lim [8] = '{14'h0200, 14'h2000, 14'h2000, 14'h1000,
                             14'h2000, 14'h2000, 14'h0001, 14'h2000};
    logic [7:0]  execute_in_place = 8'h03;
    logic [7:0]  multi = 8'hBF;
    logic [7:0]  fat = 8'hB4;
    for (int i = 0; i < 8; i++)
    begin
      boot(code[i], 99);
      chk(primary_src, src[i], "source");
      chk(search_limit, lim[i], "limit");
      chk(xip_allowed, execute_in_place[i], "xip");
      chk(multi_image_allowed, multi[i], "multi");
      chk(fat_fs_required, fat[i], "fat");
      chk(secure_allowed, 1'b1, "secure");
      chk(secondary_src, src[i], "secondary");
      chk(read_width, (i < 2) ? WID_X4 : WID_X8, "width");
      chk(boot_done, 1'b1, "done");
      chk(probes, 1, "probes");
      chk(single_transfer_rate, i < 2, "rate");
    end
  endtask
  // Widths, dual and stacked flash, pre-boot failure
  task automatic t_flash;
    for (int w = 0; w < 2; w++)
    begin
      flash_width_req = w[1:0];
      boot(4'h1, 99);
      chk(read_width, w, "width req");
      chk(single_transfer_rate, 1'b1, "rate");
    end
    chk(task_id, 4'hB, "service id");
    chk(csu_release, 1'b1, "release");
    flash_dual = 1'b1;
    boot(4'h1, 99);
    chk(xip_allowed, 1'b0, "dual xip");
    boot(4'h2, 99);
    chk(read_width, WID_X8, "dual width");
    chk(search_limit, 14'h0400, "x8 window");
    flash_dual = 1'b0;
    flash_stacked = 1'b1;
    boot(4'h1, 99);
    chk(boot_error, 1'b1, "stacked");
    chk(probes, 0, "stacked probes");
    flash_stacked = 1'b0;
    boot(4'h1, 6);
    chk(boot_error, 1'b1, "task fail");
    chk(csu_release, 1'b0, "no release");
    chk(task_id, 4'hA, "error id");
  endtask
  // Search with a bad checksum on the way, USB limits, odd codes
  task automatic t_search;
    lat = 4'h2;
    sum_bad_slot = 14'h0001;
    good_slot = 14'h0003;
    load_pmu_fw = 1'b1;
    boot(4'h1, 99);
    chk(probes, 4, "retries");
    chk(probe_addr, 32'h0001_8000, "slot addr");
    chk(boot_done, 1'b1, "found");
    chk(pmu_seen, 1'b1, "pmu fw load");
    boot(4'h7, 99);
    chk(probes, 1, "usb one try");
    chk(boot_error, 1'b1, "usb no fallback");
    good_slot = 14'h0000;
    dram_present = 1'b0;
    boot(4'h7, 99);
    chk(boot_error, 1'b1, "usb no dram");
    dram_present = 1'b1;
    usb_boot_disable_option = 1'b1;
    boot(4'h7, 99);
    chk(probes, 0, "usb disabled");
    usb_boot_disable_option = 1'b0;
    boot(4'h0, 99);
    chk(secure_allowed, 1'b0, "test port secure");
    boot(4'h8, 99);
    chk(boot_error, 1'b1, "bad code");
    chk(probes, 0, "bad code probes");
  endtask
  // Secondary device and service requests
  task automatic t_service;
    int n;
    sec_mode_valid = 1'b1;
    sec_mode_code = 4'h3;
    boot(4'h1, 99);
    chk(secondary_src, SRC_CARD0, "secondary");
    chk(service_mode, 1'b1, "service mode");
    sw_irq = 1'b1;
    tick();
    sw_irq = 1'b0;
    chk(service_ack, 1'b1, "sw ack");
    chk(service_cause, 2'h1, "sw cause");
    tick();
    hw_irq_pin = 1'b1;
    n = 0;
    while (service_ack !== 1'b1 && n < 6)
    begin
      tick();
      n++;
    end
    hw_irq_pin = 1'b0;
    chk(service_cause, 2'h2, "hw cause");
  endtask
  // Watchdog
  initial
  begin
    #160000;
    err_total++;
    test_done();
  end
  initial
  begin
    {clk, rst, sec_mode_valid, flash_dual, flash_stacked, task_done, task_fail} = 7'h20;
    {usb_boot_disable_option, load_pmu_fw, sw_irq, hw_irq_pin} = 4'h0;
    {mode_pins, sec_mode_code, lat, flash_width_req} = 14'h0002;
    {good_slot, sum_bad_slot} = {14'h0000, 14'h3FFF};
    dram_present = 1'b1;
    err_total = 0;
    checks = 0;
    t_modes();
    t_flash();
    t_search();
    t_service();
    test_done();
  end
endmodule
